// >>> inc/dtt_map.vh
// constants for the delayed toggle timer: time bases, widths and tick counts
`ifndef DTT_MAP_VH
`define DTT_MAP_VH

// delay setting and count width, largest legal setting
`define DTT_CNT_W        15
`define DTT_DELAY_MAX    15'h7FFF

// time base select codes
`define DTT_TB_W         2
`define DTT_TB_10MS      2'h0
`define DTT_TB_100MS     2'h1
`define DTT_TB_1S        2'h2

// system clock and unit times
`define DTT_CLK_HZ       50000000
`define DTT_BASE_MS      10
`define DTT_BASE_CYC     ((`DTT_CLK_HZ / 1000) * `DTT_BASE_MS)
`define DTT_DIV_100MS    10
`define DTT_DIV_1S       100
// last decade divider value, one below the divide ratio
`define DTT_DEC_LAST_100MS 7'h09
`define DTT_DEC_LAST_1S    7'h63

// prescaler widths
`define DTT_PRE_W        20
`define DTT_DEC_W        7

`endif

// >>> verilog/dtt_prescaler.v
// time base prescaler: one-cycle tick at 10 ms, 100 ms or 1 s
`timescale 1ns/1ps
`include "dtt_map.vh"

module dtt_prescaler #(
    parameter BASE_CYC = `DTT_BASE_CYC
) (
    // clock and reset
    input  wire                    sys_clk,
    input  wire                    arst_n,
    // control
    input  wire                    run,
    input  wire [`DTT_TB_W-1:0]    tb_sel,
    // tick out
    output reg                     tick
);

    // terminal count cut to the prescaler width on purpose
    localparam integer          BASE_LAST_I = BASE_CYC - 1;
    localparam [`DTT_PRE_W-1:0] BASE_LAST   = BASE_LAST_I[`DTT_PRE_W-1:0];

    reg [`DTT_PRE_W-1:0] pre_ff;
    reg [`DTT_DEC_W-1:0] dec_ff;
    wire                 base_tick;
    reg  [`DTT_DEC_W-1:0] dec_last;

    assign base_tick = run && (pre_ff == BASE_LAST);

    // decade divider end value per time base
    always @* begin
        case (tb_sel)
            `DTT_TB_100MS: dec_last = `DTT_DEC_LAST_100MS;
            `DTT_TB_1S:    dec_last = `DTT_DEC_LAST_1S;
            default:       dec_last = {`DTT_DEC_W{1'b0}};
        endcase
    end

    // counters restart whenever timing is idle so every delay starts on a full unit
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pre_ff <= {`DTT_PRE_W{1'b0}};
            dec_ff <= {`DTT_DEC_W{1'b0}};
            tick   <= 1'b0;
        end else if (!run) begin
            pre_ff <= {`DTT_PRE_W{1'b0}};
            dec_ff <= {`DTT_DEC_W{1'b0}};
            tick   <= 1'b0;
        end else begin
            tick <= 1'b0;
            if (base_tick) begin
                pre_ff <= {`DTT_PRE_W{1'b0}};
                if (dec_ff >= dec_last) begin
                    dec_ff <= {`DTT_DEC_W{1'b0}};
                    tick   <= 1'b1;                 // RULE_09
                end else begin
                    dec_ff <= dec_ff + 7'h01;
                end
            end else begin
                pre_ff <= pre_ff + 20'h00001;
            end
        end
    end

endmodule // dtt_prescaler

// >>> verilog/dtt_delayed_toggle_block.v
// delayed toggle timer: edge-started delay, then output inversion
`timescale 1ns/1ps
`include "dtt_map.vh"
//
// Overview of operation
// RULE_01: trigger and clear bit inputs start and cancel the delayed toggle.
// RULE_02: delay setting ranges from zero to 32767 time-base units.
// RULE_03: time base unit selectable as 10 ms, 100 ms or 1 s.
// RULE_04: only an off-to-on trigger transition starts timing; steady levels do not.
// RULE_05: when count reaches setting, the bit output inverts.
// RULE_06: clear on zeroes the running count and forces output off.
// RULE_07: delay setting and running count are offered as word outputs.
// RULE_08: user must pick a delay not shorter than one scan period.
// RULE_09: prescaler derives ticks from system clock; count advances once per tick.
// RULE_10: clear held ignores triggers; after toggling, count stops until next edge.

module dtt_delayed_toggle_block #(
    parameter BASE_CYC = `DTT_BASE_CYC
) (
    // clock and reset
    input  wire                    sys_clk,
    input  wire                    arst_n,
    // bit inputs from other blocks
    input  wire                    trigger,
    input  wire                    clear,
    // configuration
    input  wire [`DTT_CNT_W-1:0]   delay_setting,
    input  wire [`DTT_TB_W-1:0]    time_base,
    // bit output
    output reg                     toggle_out,
    // word outputs and timing flag
    output reg  [`DTT_CNT_W-1:0]   delay_word,
    output reg  [`DTT_CNT_W-1:0]   count_word,
    output wire                    timing
);

    reg                  trig_d_ff;
    reg                  run_ff;
    reg [`DTT_CNT_W-1:0] cnt_ff;
    reg                  out_ff;
    reg                  nxt_run;
    reg [`DTT_CNT_W-1:0] nxt_cnt;
    reg                  nxt_out;
    wire                 rise;
    wire                 tick;
    wire                 done;

    // inputs come from same-clock logic, so no synchroniser
    assign rise   = trigger && !trig_d_ff;       // RULE_04
    assign done   = run_ff && (cnt_ff >= delay_setting);
    assign timing = run_ff;

    dtt_prescaler #(
        .BASE_CYC (BASE_CYC)
    ) u_pre (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .run     (run_ff && !done),
        .tb_sel  (time_base),                    // RULE_03
        .tick    (tick)
    );

    // next state: clear wins over everything, then trigger edge, then counting
    always @* begin
        nxt_run = run_ff;
        nxt_cnt = cnt_ff;
        nxt_out = out_ff;
        if (clear) begin                         // RULE_01
            nxt_run = 1'b0;                      // RULE_10
            nxt_cnt = {`DTT_CNT_W{1'b0}};        // RULE_06
            nxt_out = 1'b0;                      // RULE_06
        end else if (rise && !run_ff) begin
            // a delay of zero toggles on the following cycle
            nxt_run = 1'b1;
            nxt_cnt = {`DTT_CNT_W{1'b0}};
        end else if (done) begin
            nxt_out = !out_ff;                   // RULE_05
            nxt_run = 1'b0;                      // RULE_10
        end else if (run_ff && tick) begin
            nxt_cnt = cnt_ff + 15'h0001;         // RULE_09
        end
    end

    // state registers; count holds its final value after the toggle
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            trig_d_ff <= 1'b0;
            run_ff    <= 1'b0;
            cnt_ff    <= {`DTT_CNT_W{1'b0}};
            out_ff    <= 1'b0;
        end else begin
            trig_d_ff <= trigger;
            run_ff    <= nxt_run;
            cnt_ff    <= nxt_cnt;
            out_ff    <= nxt_out;
        end
    end

    // registered outputs; setting is 15 bits so it never exceeds the maximum
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            toggle_out <= 1'b0;
            delay_word <= {`DTT_CNT_W{1'b0}};
            count_word <= {`DTT_CNT_W{1'b0}};
        end else begin
            toggle_out <= nxt_out;
            delay_word <= delay_setting;         // RULE_02
            count_word <= nxt_cnt;               // RULE_07
        end
    end

endmodule // dtt_delayed_toggle_block

// >>> bench/dtt_partner.sv
// partner model: a module driving trigger and clear, registered from the bench requests once per clock
`timescale 1ns/1ps
module dtt_partner (
    // clock
    input  wire sys_clk,
    // requests from the bench
    input  wire fire,
    input  wire hold,
    // levels to the block
    output reg  trigger = 1'b0,
    output reg  clear = 1'b0
);
    // levels stand a whole scan, so no edge is shorter than the scan period
    always @(posedge sys_clk) begin
        trigger <= fire;
        clear <= hold;
    end
endmodule // dtt_partner

// >>> bench/dtt_monitor.sv
// port checker of the delayed toggle timer
`timescale 1ns/1ps
`include "dtt_map.vh"
module dtt_monitor #(parameter BASE_CYC = `DTT_BASE_CYC) (
    // clock and reset
    input  wire                  sys_clk,
    input  wire                  arst_n,
    // block ports
    input  wire                  trigger,
    input  wire                  clear,
    input  wire [`DTT_CNT_W-1:0] delay_setting,
    input  wire [`DTT_TB_W-1:0]  time_base,
    input  wire                  toggle_out,
    input  wire [`DTT_CNT_W-1:0] delay_word,
    input  wire [`DTT_CNT_W-1:0] count_word,
    input  wire                  timing
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    property p_clr; clear |=> !toggle_out && count_word == 15'h0 && !timing; endproperty
    a_clr: assert property (p_clr) else $error("clear ignored");
    property p_go; $rose(trigger) && !clear && !timing |=> timing && count_word == 15'h0;
    endproperty
    a_go: assert property (p_go) else $error("no start");
    property p_lvl; !timing && !$rose(trigger) |=> !timing; endproperty
    a_lvl: assert property (p_lvl) else $error("level start");
    property p_flip; timing && !clear && count_word >= delay_setting
        |=> toggle_out != $past(toggle_out) && !timing; endproperty
    a_flip: assert property (p_flip) else $error("no toggle");
    property p_keep; !timing && !clear |=> $stable(toggle_out); endproperty
    a_keep: assert property (p_keep) else $error("stray toggle");
    property p_step; timing && !clear |=> count_word - $past(count_word) <= 15'h1; endproperty
    a_step: assert property (p_step) else $error("bad step");
    property p_idle; !timing && !clear |=> $stable(count_word) || count_word == 15'h0;
    endproperty
    a_idle: assert property (p_idle) else $error("count moved");
    property p_word; 1'b1 |=> delay_word == $past(delay_setting); endproperty
    a_word: assert property (p_word) else $error("delay word");
    // main scenarios reached
    c_flip: cover property ($rose(toggle_out));
    c_clr: cover property (clear && timing);
    c_slow: cover property (timing && time_base == 2'h2);
endmodule // dtt_monitor
bind dtt_delayed_toggle_block dtt_monitor #(.BASE_CYC(BASE_CYC)) u_mon (.sys_clk(sys_clk),
    .arst_n(arst_n), .trigger(trigger), .clear(clear), .delay_setting(delay_setting),
    .time_base(time_base), .toggle_out(toggle_out), .delay_word(delay_word),
    .count_word(count_word), .timing(timing));

// >>> bench/dtt_delayed_toggle_block_tb.sv
// self-checking testbench of the delayed toggle timer
`timescale 1ns/1ps
`include "dtt_map.vh"
module dtt_delayed_toggle_block_tb;
    // short unit keeps the 1 s base to a few hundred cycles
    localparam N = 4;
    reg                  sys_clk = 1'b0;
    reg                  arst_n = 1'b0;
    reg                  fire = 1'b0;
    reg                  hold = 1'b0;
    reg                  old;
    reg [`DTT_CNT_W-1:0] ds = 15'h0;
    reg [`DTT_TB_W-1:0]  tbs = 2'h0;
    wire                 trigger, clear, toggle_out, timing;
    wire [`DTT_CNT_W-1:0] delay_word, count_word;
    integer              fails = 0, tests_run = 0, n;
    dtt_partner peer (.sys_clk(sys_clk), .fire(fire), .hold(hold), .trigger(trigger),
        .clear(clear));
    dtt_delayed_toggle_block #(.BASE_CYC(N)) dut (.sys_clk(sys_clk), .arst_n(arst_n),
        .trigger(trigger), .clear(clear), .delay_setting(ds), .time_base(tbs),
        .toggle_out(toggle_out), .delay_word(delay_word), .count_word(count_word),
        .timing(timing));
    initial forever #10 sys_clk = ~sys_clk;
    task chk(input string what, input [31:0] e, input [31:0] g);
        tests_run = tests_run + 1;
        if (e !== g) begin
            fails = fails + 1;
            $display("[ERR] %0s exp %0h got %0h", what, e, g);
        end
    endtask
    task end_of_test;
        $display("checks %0d errors %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // one edge, then trigger held high: the level must not restart timing
    task t_delay(input [14:0] d, input [1:0] tb, input [31:0] e);
        old = toggle_out;
        ds = d;
        tbs = tb;
        fire = 1'b1;
        n = 0;
        repeat (2) @(posedge sys_clk);
        #1;
        while (toggle_out === old && n < 3000) begin
            @(posedge sys_clk);
            #1;
            n = n + 1;
        end
        chk("cycles", e, n);
        chk("toggle", !old, toggle_out);
        chk("count", d, count_word);
        chk("delay", d, delay_word);
        repeat (20) @(posedge sys_clk);
        #1;
        chk("steady", !old, toggle_out);
        chk("stop", 1'b0, timing);
        fire = 1'b0;
        @(posedge sys_clk);
        #1;
    endtask
    // clear in mid-delay, then an edge while clear is held
    task t_clear;
        ds = 15'h7FFF;
        fire = 1'b1;
        repeat (30) @(posedge sys_clk);
        #1;
        chk("run", 1'b1, timing);
        hold = 1'b1;
        fire = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        chk("toggle", 1'b0, toggle_out);
        chk("count", 15'h0, count_word);
        fire = 1'b1;
        repeat (4) @(posedge sys_clk);
        #1;
        chk("held", 1'b0, timing);
        hold = 1'b0;
    endtask
    initial begin
        repeat (3) @(posedge sys_clk);
        #1 arst_n = 1'b1;
        // cycles counted from the edge that starts timing: zero delay toggles on the next one,
        // otherwise the last tick plus one edge to count and one to toggle
        t_delay(15'h0, 2'h0, 1);
        t_delay(15'h2, 2'h0, 2 * N + 2);
        t_delay(15'h1, 2'h1, 10 * N + 2);
        t_delay(15'h1, 2'h2, 100 * N + 2);
        t_delay(15'h1, 2'h3, N + 2);
        t_clear;
        end_of_test;
    end
    // watchdog well beyond the few hundred cycles the run needs
    initial begin
        #100000;
        fails = fails + 1;
        end_of_test;
    end
endmodule // dtt_delayed_toggle_block_tb
